// ==== bdm_defines.svh ====
// constants for the banked data memory and status block
`ifndef BDM_DEFINES_SVH
`define BDM_DEFINES_SVH

// ****************************************************************
// address layout
// ****************************************************************
`define BDM_NUM_BANKS 32
`define BDM_BANK_BYTES 128
`define BDM_ADDR_W 12
`define BDM_BANK_W 5
`define BDM_OFS_W 7

// ****************************************************************
// core register offsets
// ****************************************************************
`define BDM_OFS_INDIRECT_DATA_ZERO 7'h00
`define BDM_OFS_INDIRECT_DATA_ONE 7'h01
`define BDM_OFS_PROGRAM_COUNTER_LOW 7'h02
`define BDM_OFS_ARITH_RESET_FLAGS 7'h03
`define BDM_OFS_POINTER_ZERO_LOW 7'h04
`define BDM_OFS_POINTER_ZERO_HIGH 7'h05
`define BDM_OFS_POINTER_ONE_LOW 7'h06
`define BDM_OFS_POINTER_ONE_HIGH 7'h07
`define BDM_OFS_BANK_NUMBER_SELECT 7'h08
`define BDM_OFS_WORKING_ACCUMULATOR 7'h09
`define BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH 7'h0a
`define BDM_OFS_INTERRUPT_CONTROL 7'h0b

// ****************************************************************
// region bounds within a bank
// ****************************************************************
`define BDM_CORE_LAST 7'h0b
`define BDM_PERIPH_FIRST 7'h0c
`define BDM_PERIPH_LAST 7'h1f
`define BDM_GRAM_FIRST 7'h20
`define BDM_GRAM_LAST 7'h6f
`define BDM_GRAM_BYTES 80
`define BDM_GRAM_BANK 5'h00
`define BDM_CRAM_FIRST 7'h70
`define BDM_CRAM_BYTES 16

// ****************************************************************
// status field positions and reset values
// ****************************************************************
`define BDM_ST_CARRY 0
`define BDM_ST_NIBBLE 1
`define BDM_ST_ZERO 2
`define BDM_ST_SLEEP 3
`define BDM_ST_EXPIRY 4
`define BDM_PTR_PROG_BIT 15
`define BDM_RST_BYTE 8'h00
`define BDM_RST_PTR 16'h0000

`endif

// ==== bdm_pkg.sv ====
// types shared by the banked data memory and status block
package bdm_pkg;

  typedef enum logic [3:0] {
    BDM_OP_NONE,
    BDM_OP_READ,
    BDM_OP_WRITE,
    BDM_OP_LOGIC,
    BDM_OP_ADD,
    BDM_OP_SUB,
    BDM_OP_ROT_RIGHT,
    BDM_OP_ROT_LEFT,
    BDM_OP_CLEAR
  } bdm_op_t;

  typedef struct packed {
    bdm_op_t op;
    logic to_file;
    logic [6:0] offset;
    logic [7:0] operand_a;
    logic [7:0] operand_b;
  } bdm_req_t;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [7:0] wdata;
  } bdm_periph_t;

endpackage : bdm_pkg

// ==== bdm_data_memory.sv ====
// banked data memory decoder with core registers and status flags
`timescale 1ns/1ps
`include "bdm_defines.svh"

// What this block does
// RULE_01: data storage is 32 banks of 128 byte locations each.
// RULE_02: each bank holds 12 core, 20 peripheral, up to 80 general, 16 common bytes.
// RULE_03: direct accesses use the bank number held in bank select.
// RULE_04: reads of unimplemented locations return zero.
// RULE_05: 12-bit data address: upper five bits bank, lower seven bits offset.
// RULE_06: core registers sit at offsets 0x00-0x0b of every bank.
// RULE_07: fixed core offsets: indirect data, counter, status, pointers, bank, accumulator.
// RULE_08: flag-affecting ops on status discard written Z, DC, C; result flags win.
// RULE_09: expiry and sleep flags ignore all instruction writes.
// RULE_10: clearing status clears upper three bits, sets zero, keeps other flags.
// RULE_11: software should alter status only with flag-neutral instructions.
// RULE_12: status bits 7 to 5 read as zero.
// RULE_13: expiry flag set by power-up, watchdog clear, sleep; cleared on expiry.
// RULE_14: sleep flag set by power-up or watchdog clear; cleared by sleep.
// RULE_15: zero flag follows whether the operation result is zero.
// RULE_16: add/sub set nibble flag on carry out of bit 3.
// RULE_17: add/sub set carry flag on carry out of bit 7.
// RULE_18: subtract adds two's complement, so carries are active-low borrows.
// RULE_19: rotates load carry from low or high source bit.
// RULE_20: power-on sets expiry and sleep, clears arithmetic flags; other resets keep them.
// RULE_21: peripheral control registers occupy offsets 0x0c-0x1f of every bank.
// RULE_22: sixteen common bytes reach the same storage from every bank.
// RULE_23: common RAM decodes at offsets 0x70-0x7f in all banks.
// RULE_24: bank select holds five bits forming the upper direct address bits.

module bdm_data_memory (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic other_rst_i,
  input wire logic ce_i,
  // instruction request
  input wire bdm_pkg::bdm_req_t req_i,
  // power-state events
  input wire logic watchdog_clear_instr_i,
  input wire logic sleep_instr_i,
  input wire logic watchdog_timer_expired_i,
  // peripheral control register port
  output bdm_pkg::bdm_periph_t periph_o,
  input wire logic [7:0] periph_rdata_i,
  // results and core register view
  output logic [7:0] rd_data_o,
  output logic [7:0] result_o,
  output logic [7:0] arith_reset_flags_o,
  output logic [7:0] working_accumulator_o,
  output logic [4:0] bank_number_select_o,
  output logic [7:0] program_counter_low_o,
  output logic [7:0] program_counter_latch_high_o,
  output logic [7:0] interrupt_control_o,
  output logic [15:0] pointer_zero_o,
  output logic [15:0] pointer_one_o
);

  // ****************************************************************
  // state
  // ****************************************************************
  logic [4:0] bank_reg;
  logic [7:0] wacc_reg;
  logic [7:0] pcl_reg;
  logic [7:0] program_counter_latch_high_reg;
  logic [7:0] interrupt_control_reg;
  logic [15:0] ptr0_reg;
  logic [15:0] ptr1_reg;
  logic expiry_reg;
  logic sleep_reg;
  logic zero_reg;
  logic nibble_reg;
  logic carry_reg;
  logic [7:0] rd_data_reg;
  logic [7:0] result_reg;
  bdm_pkg::bdm_periph_t periph_reg;
  logic [7:0] gram_reg [`BDM_GRAM_BYTES];
  logic [7:0] cram_reg [`BDM_CRAM_BYTES];

  // ****************************************************************
  // functions
  // ****************************************************************
  // core register offsets alias in every bank
  function automatic logic is_core(input logic [6:0] ofs);
    is_core = (ofs <= `BDM_CORE_LAST); // RULE_06
  endfunction : is_core

  function automatic logic is_periph(input logic [6:0] ofs);
    is_periph = (ofs >= `BDM_PERIPH_FIRST) && (ofs <= `BDM_PERIPH_LAST); // RULE_21
  endfunction : is_periph

  function automatic logic is_cram(input logic [6:0] ofs);
    is_cram = (ofs >= `BDM_CRAM_FIRST); // RULE_23
  endfunction : is_cram

  // general RAM is built only in one bank; the rest read as zero
  function automatic logic is_gram(input logic [11:0] addr);
    is_gram = (addr[11:7] == `BDM_GRAM_BANK) && (addr[6:0] >= `BDM_GRAM_FIRST)
      && (addr[6:0] <= `BDM_GRAM_LAST); // RULE_02
  endfunction : is_gram

  // 9-bit sum so the top bit is the carry out of bit 7
  function automatic logic [8:0] add9(input logic [7:0] a, input logic [7:0] b, input logic cin);
    add9 = {1'b0, a} + {1'b0, b} + {8'h00, cin};
  endfunction : add9

  function automatic logic [4:0] add5(input logic [3:0] a, input logic [3:0] b, input logic cin);
    add5 = {1'b0, a} + {1'b0, b} + {4'h0, cin};
  endfunction : add5

  // ****************************************************************
  // address resolution
  // ****************************************************************
  wire logic ofs_is_ind0 = (req_i.offset == `BDM_OFS_INDIRECT_DATA_ZERO);
  wire logic ofs_is_ind1 = (req_i.offset == `BDM_OFS_INDIRECT_DATA_ONE);
  wire logic use_pointer = ofs_is_ind0 || ofs_is_ind1;
  wire logic [15:0] sel_ptr = ofs_is_ind1 ? ptr1_reg : ptr0_reg;
  // program-memory reads through a pointer are not served here
  wire logic ptr_to_prog = use_pointer && sel_ptr[`BDM_PTR_PROG_BIT];
  wire logic [11:0] eff_addr = use_pointer ? sel_ptr[11:0]
    : {bank_reg, req_i.offset}; // RULE_03 RULE_05 RULE_24
  wire logic [6:0] eff_ofs = eff_addr[6:0]; // RULE_01
  // a pointer aimed back at an indirect slot reaches nothing
  wire logic eff_loops = use_pointer && (eff_ofs <= `BDM_OFS_INDIRECT_DATA_ONE);
  wire logic eff_valid = !ptr_to_prog && !eff_loops;
  wire logic hit_core = eff_valid && is_core(eff_ofs);
  wire logic hit_periph = eff_valid && is_periph(eff_ofs);
  wire logic hit_cram = eff_valid && is_cram(eff_ofs); // RULE_22
  wire logic hit_gram = eff_valid && is_gram(eff_addr);
  wire logic [3:0] cram_idx = eff_ofs[3:0];
  wire logic [6:0] gram_idx = eff_ofs - `BDM_GRAM_FIRST;

  // ****************************************************************
  // flag arithmetic
  // ****************************************************************
  wire logic op_add = (req_i.op == bdm_pkg::BDM_OP_ADD);
  wire logic op_sub = (req_i.op == bdm_pkg::BDM_OP_SUB);
  wire logic op_rr = (req_i.op == bdm_pkg::BDM_OP_ROT_RIGHT);
  wire logic op_rl = (req_i.op == bdm_pkg::BDM_OP_ROT_LEFT);
  wire logic op_clr = (req_i.op == bdm_pkg::BDM_OP_CLEAR);
  wire logic op_logic = (req_i.op == bdm_pkg::BDM_OP_LOGIC);
  wire logic op_arith = op_add || op_sub;
  wire logic op_rot = op_rr || op_rl;
  // subtract is a + ~b + 1, so carry means no borrow
  wire logic [7:0] addend = op_sub ? ~req_i.operand_b : req_i.operand_b; // RULE_18
  wire logic [8:0] sum9 = add9(req_i.operand_a, addend, op_sub);
  wire logic [4:0] nib5 = add5(req_i.operand_a[3:0], addend[3:0], op_sub);
  wire logic [7:0] rot_val = op_rr ? {carry_reg, req_i.operand_a[7:1]}
    : {req_i.operand_a[6:0], carry_reg};
  wire logic [7:0] op_result = op_arith ? sum9[7:0]
    : op_rot ? rot_val
    : op_clr ? 8'h00
    : req_i.operand_a;
  wire logic sets_zero = op_arith || op_logic || op_clr;
  wire logic sets_nibble = op_arith;
  wire logic sets_carry = op_arith || op_rot;
  wire logic zero_val = (op_result == 8'h00); // RULE_15 RULE_10
  wire logic nibble_val = nib5[4]; // RULE_16
  wire logic carry_val = op_arith ? sum9[8]
    : op_rr ? req_i.operand_a[0]
    : req_i.operand_a[7]; // RULE_17 RULE_19

  // ****************************************************************
  // write decode
  // ****************************************************************
  wire logic op_writes = (req_i.op != bdm_pkg::BDM_OP_NONE) && (req_i.op != bdm_pkg::BDM_OP_READ);
  wire logic file_wr = ce_i && op_writes && req_i.to_file;
  wire logic acc_wr_dest = ce_i && op_writes && !req_i.to_file;
  wire logic core_wr = file_wr && hit_core;
  wire logic wr_status = core_wr && (eff_ofs == `BDM_OFS_ARITH_RESET_FLAGS)
    && !sets_zero && !sets_carry; // RULE_08 RULE_10
  wire logic wr_bank = core_wr && (eff_ofs == `BDM_OFS_BANK_NUMBER_SELECT);
  wire logic wr_wacc = (core_wr && (eff_ofs == `BDM_OFS_WORKING_ACCUMULATOR)) || acc_wr_dest;
  wire logic wr_pcl = core_wr && (eff_ofs == `BDM_OFS_PROGRAM_COUNTER_LOW);
  wire logic wr_program_counter_latch_high = core_wr && (eff_ofs == `BDM_OFS_PROGRAM_COUNTER_LATCH_HIGH);
  wire logic wr_interrupt_control = core_wr && (eff_ofs == `BDM_OFS_INTERRUPT_CONTROL);
  wire logic wr_p0l = core_wr && (eff_ofs == `BDM_OFS_POINTER_ZERO_LOW);
  wire logic wr_p0h = core_wr && (eff_ofs == `BDM_OFS_POINTER_ZERO_HIGH);
  wire logic wr_p1l = core_wr && (eff_ofs == `BDM_OFS_POINTER_ONE_LOW);
  wire logic wr_p1h = core_wr && (eff_ofs == `BDM_OFS_POINTER_ONE_HIGH);
  wire logic wr_gram = file_wr && hit_gram;
  wire logic wr_cram = file_wr && hit_cram;
  wire logic wr_periph = file_wr && hit_periph;
  wire logic rd_periph = ce_i && (req_i.op != bdm_pkg::BDM_OP_NONE) && hit_periph;

  // ****************************************************************
  // status next values
  // ****************************************************************
  // a flag-affecting op owns Z, DC and C even when status is the target
  wire logic zero_next = (ce_i && sets_zero) ? zero_val
    : wr_status ? op_result[`BDM_ST_ZERO] : zero_reg; // RULE_08
  wire logic nibble_next = (ce_i && sets_nibble) ? nibble_val
    : wr_status ? op_result[`BDM_ST_NIBBLE] : nibble_reg; // RULE_08
  wire logic carry_next = (ce_i && sets_carry) ? carry_val
    : wr_status ? op_result[`BDM_ST_CARRY] : carry_reg; // RULE_08
  // only power events move these; the set wins over an expiry in the same cycle
  wire logic expiry_next = (watchdog_clear_instr_i || sleep_instr_i) ? 1'b1
    : watchdog_timer_expired_i ? 1'b0 : expiry_reg; // RULE_09 RULE_13
  wire logic sleep_next = watchdog_clear_instr_i ? 1'b1
    : sleep_instr_i ? 1'b0 : sleep_reg; // RULE_09 RULE_14
  wire logic [7:0] status_view = {3'b000, expiry_reg, sleep_reg, zero_reg, nibble_reg,
    carry_reg}; // RULE_12

  // ****************************************************************
  // read mux
  // ****************************************************************
  logic [7:0] core_rd;
  always_comb
  begin
    unique case (eff_ofs[3:0])
      4'h2: core_rd = pcl_reg;
      4'h3: core_rd = status_view;
      4'h4: core_rd = ptr0_reg[7:0];
      4'h5: core_rd = ptr0_reg[15:8];
      4'h6: core_rd = ptr1_reg[7:0];
      4'h7: core_rd = ptr1_reg[15:8];
      4'h8: core_rd = {3'b000, bank_reg};
      4'h9: core_rd = wacc_reg;
      4'ha: core_rd = program_counter_latch_high_reg;
      4'hb: core_rd = interrupt_control_reg;
      default: core_rd = 8'h00;
    endcase // RULE_07
  end

  // holes, unbuilt RAM and pointer loops all read zero
  wire logic [7:0] rd_mux = hit_core ? core_rd
    : hit_periph ? 8'h00
    : hit_cram ? cram_reg[cram_idx]
    : hit_gram ? gram_reg[gram_idx]
    : 8'h00; // RULE_04
  wire logic rd_take = ce_i && (req_i.op != bdm_pkg::BDM_OP_NONE);

  // ****************************************************************
  // status and core registers
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      expiry_reg <= 1'b1; // RULE_20
      sleep_reg <= 1'b1;
      zero_reg <= 1'b0;
      nibble_reg <= 1'b0;
      carry_reg <= 1'b0;
    end
    else if (ce_i && !other_rst_i)
    begin
      expiry_reg <= expiry_next;
      sleep_reg <= sleep_next;
      zero_reg <= zero_next;
      nibble_reg <= nibble_next;
      carry_reg <= carry_next;
    end
  end

  // other resets clear the core registers but keep the status flags
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || (ce_i && other_rst_i))
    begin
      bank_reg <= 5'h00;
      wacc_reg <= `BDM_RST_BYTE;
      pcl_reg <= `BDM_RST_BYTE;
      program_counter_latch_high_reg <= `BDM_RST_BYTE;
      interrupt_control_reg <= `BDM_RST_BYTE;
      ptr0_reg <= `BDM_RST_PTR;
      ptr1_reg <= `BDM_RST_PTR;
    end
    else if (ce_i)
    begin
      if (wr_bank)
        bank_reg <= op_result[4:0]; // RULE_24
      if (wr_wacc)
        wacc_reg <= op_result;
      if (wr_pcl)
        pcl_reg <= op_result;
      if (wr_program_counter_latch_high)
        program_counter_latch_high_reg <= op_result;
      if (wr_interrupt_control)
        interrupt_control_reg <= op_result;
      if (wr_p0l)
        ptr0_reg[7:0] <= op_result;
      if (wr_p0h)
        ptr0_reg[15:8] <= op_result;
      if (wr_p1l)
        ptr1_reg[7:0] <= op_result;
      if (wr_p1h)
        ptr1_reg[15:8] <= op_result;
    end
  end

  // ****************************************************************
  // RAM storage
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i)
    begin
      for (int i = 0; i < `BDM_GRAM_BYTES; i++)
        gram_reg[i] <= `BDM_RST_BYTE;
      for (int j = 0; j < `BDM_CRAM_BYTES; j++)
        cram_reg[j] <= `BDM_RST_BYTE;
    end
    else if (ce_i && !other_rst_i)
    begin
      if (wr_gram)
        gram_reg[gram_idx] <= op_result; // RULE_02
      if (wr_cram)
        cram_reg[cram_idx] <= op_result; // RULE_22 RULE_23
    end
  end

  // ****************************************************************
  // read data, result and peripheral port
  // ****************************************************************
  always_ff @(posedge clk_sys_i)
  begin
    if (sys_rst_i || (ce_i && other_rst_i))
    begin
      rd_data_reg <= 8'h00;
      result_reg <= 8'h00;
      periph_reg <= '0;
    end
    else if (ce_i)
    begin
      // a peripheral byte lands with its strobe; a new request wins
      if (rd_take)
        rd_data_reg <= rd_mux;
      else if (periph_reg.rd)
        rd_data_reg <= periph_rdata_i; // RULE_21
      if (op_writes)
        result_reg <= op_result;
      periph_reg.wr <= wr_periph; // RULE_21
      periph_reg.rd <= rd_periph && !wr_periph;
      periph_reg.addr <= eff_addr;
      periph_reg.wdata <= op_result;
    end
  end

  // ****************************************************************
  // outputs
  // ****************************************************************
  assign rd_data_o = rd_data_reg;
  assign result_o = result_reg;
  assign periph_o = periph_reg;
  assign arith_reset_flags_o = status_view;
  assign working_accumulator_o = wacc_reg;
  assign bank_number_select_o = bank_reg;
  assign program_counter_low_o = pcl_reg;
  assign program_counter_latch_high_o = program_counter_latch_high_reg;
  assign interrupt_control_o = interrupt_control_reg;
  assign pointer_zero_o = ptr0_reg;
  assign pointer_one_o = ptr1_reg;

endmodule : bdm_data_memory

// ==== bdm_data_memory_sva.sv ====
// assertion checker for the banked data memory block
`timescale 1ns/1ps
module bdm_data_memory_sva (
  // clock and resets
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  input wire logic other_rst_i,
  input wire logic ce_i,
  // requests and events
  input wire bdm_pkg::bdm_req_t req_i,
  input wire logic watchdog_clear_instr_i,
  input wire logic sleep_instr_i,
  input wire logic watchdog_timer_expired_i,
  // observed outputs
  input wire bdm_pkg::bdm_periph_t periph_o,
  input wire logic [7:0] rd_data_o,
  input wire logic [7:0] arith_reset_flags_o,
  input wire logic [4:0] bank_number_select_o
);
  // ****************************************************************
  // helper logic
  // ****************************************************************
  bdm_pkg::bdm_req_t req_q;
  logic [7:0] st_q;
  logic [2:0] fl_q;
  wire go = ce_i & ~other_rst_i;
  wire quiet = ~(watchdog_clear_instr_i | sleep_instr_i | watchdog_timer_expired_i);
  wire is_sub = req_i.op == bdm_pkg::BDM_OP_SUB;
  wire is_arith = is_sub | (req_i.op == bdm_pkg::BDM_OP_ADD);
  wire is_rot = (req_i.op == bdm_pkg::BDM_OP_ROT_RIGHT) | (req_i.op == bdm_pkg::BDM_OP_ROT_LEFT);
  wire is_wr = req_i.to_file & (req_i.op == bdm_pkg::BDM_OP_WRITE);
  wire at_status = req_i.to_file & (req_i.offset == 7'h03);
  // subtract as add of the complement, so carry out means no borrow
  wire [8:0] sum = {1'b0, req_i.operand_a} + (is_sub ? {1'b0, ~req_i.operand_b} + 9'h001 : {1'b0, req_i.operand_b});
  wire [4:0] nib = {1'b0, req_i.operand_a[3:0]}
    + (is_sub ? {1'b0, ~req_i.operand_b[3:0]} + 5'h01 : {1'b0, req_i.operand_b[3:0]});
  wire [2:0] fl = {sum[7:0] == 8'h00, nib[4], sum[8]};
  always_ff @(posedge clk_sys_i)
  begin
    req_q <= req_i;
    st_q <= arith_reset_flags_o;
    fl_q <= fl;
  end
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (sys_rst_i);
  // ****************************************************************
  // assertions
  // ****************************************************************
  a_upper_bits_zero: assert property (arith_reset_flags_o[7:5] == 3'h0)
    else $error("status upper bits not zero");
  a_arith_flags_match: assert property (go && is_arith
    |=> arith_reset_flags_o[2:0] == fl_q)
    else $error("arithmetic flags wrong");
  a_rotate_carry_load: assert property (go && is_rot |=>
    arith_reset_flags_o[0] == ((req_q.op == bdm_pkg::BDM_OP_ROT_RIGHT) ? req_q.operand_a[0] : req_q.operand_a[7]))
    else $error("rotate carry wrong");
  a_expiry_clears: assert property (go && watchdog_timer_expired_i
    && !watchdog_clear_instr_i && !sleep_instr_i |=> !arith_reset_flags_o[4])
    else $error("expiry flag not cleared");
  a_sleep_entry_flags: assert property (go && sleep_instr_i && !watchdog_clear_instr_i
    |=> arith_reset_flags_o[4:3] == 2'b10)
    else $error("sleep flags wrong");
  a_wd_clear_flags: assert property (go && watchdog_clear_instr_i
    |=> arith_reset_flags_o[4:3] == 2'b11)
    else $error("watchdog clear flags wrong");
  a_status_write_guard: assert property (go && quiet && is_wr && at_status
    |=> arith_reset_flags_o[4:0] == {st_q[4:3], req_q.operand_a[2:0]})
    else $error("status write wrong");
  a_clear_status_result: assert property (go && quiet && at_status
    && req_i.op == bdm_pkg::BDM_OP_CLEAR |=> arith_reset_flags_o == {3'h0, st_q[4:3], 1'b1, st_q[1:0]})
    else $error("status clear wrong");
  a_bank_select_load: assert property (go && is_wr && req_i.offset == 7'h08
    |=> bank_number_select_o == req_q.operand_a[4:0])
    else $error("bank select wrong");
  a_periph_write_addr: assert property (go && is_wr && req_i.offset inside {[7'h0c:7'h1f]}
    |=> periph_o.wr && periph_o.addr == {$past(bank_number_select_o), req_q.offset}
    && periph_o.wdata == req_q.operand_a)
    else $error("peripheral write wrong");
  a_unbuilt_reads_zero: assert property (go && req_i.op == bdm_pkg::BDM_OP_READ
    && bank_number_select_o != 5'h00 && req_i.offset inside {[7'h20:7'h6f]} |=> rd_data_o == 8'h00)
    else $error("unbuilt read not zero");
  a_other_rst_keep: assert property (ce_i && other_rst_i && quiet |=> arith_reset_flags_o == st_q)
    else $error("status changed by other reset");
endmodule : bdm_data_memory_sva

bind bdm_data_memory bdm_data_memory_sva bdm_data_memory_sva_i (
  .clk_sys_i(clk_sys_i),
  .sys_rst_i(sys_rst_i),
  .other_rst_i(other_rst_i),
  .ce_i(ce_i),
  .req_i(req_i),
  .watchdog_clear_instr_i(watchdog_clear_instr_i),
  .sleep_instr_i(sleep_instr_i),
  .watchdog_timer_expired_i(watchdog_timer_expired_i),
  .periph_o(periph_o),
  .rd_data_o(rd_data_o),
  .arith_reset_flags_o(arith_reset_flags_o),
  .bank_number_select_o(bank_number_select_o)
);

// ==== bdm_periph_model.sv ====
// peripheral control register model on the block's register port
`timescale 1ns/1ps
module bdm_periph_model (
  // clock
  input wire logic clk_sys_i,
  // register port from the block
  input wire bdm_pkg::bdm_periph_t periph_i,
  output logic [7:0] rdata_o
);
  // ****************************************************************
  // storage
  // ****************************************************************
  logic [7:0] regs [0:4095];
  logic [7:0] last = 8'h00;
  always @(posedge clk_sys_i)
  begin
    if (periph_i.wr)
      regs[periph_i.addr] <= periph_i.wdata;
    if (periph_i.rd)
      last <= rdata_o;
  end
  // outside a read the lines show the inverse, so a stale match cannot pass
  assign rdata_o = periph_i.rd ? regs[periph_i.addr] : ~last;
endmodule : bdm_periph_model

// ==== tb_top.sv ====
// testbench for the banked data memory block
`timescale 1ns/1ps
module tb_top;
  logic clk_sys_i;
  logic sys_rst_i = 1'b1;
  logic other_rst_i = 1'b0;
  logic ce_i = 1'b1;
  logic [2:0] pwr = 3'h0;
  bdm_pkg::bdm_req_t req_i = '0;
  bdm_pkg::bdm_periph_t periph_o;
  logic [7:0] prd;
  logic [7:0] rd_data_o;
  logic [7:0] res;
  logic [7:0] flags;
  logic [7:0] accum;
  logic [4:0] bank;
  int n_errors = 0;
  int n_checks = 0;
  logic [7:0] va [8] = '{8'h0f, 8'hff, 8'h80, 8'h12, 8'h05, 8'h03, 8'h10, 8'h22};
  logic [7:0] vb [8] = '{8'h01, 8'h01, 8'h80, 8'h34, 8'h03, 8'h05, 8'h01, 8'h22};
  logic [6:0] core_ofs [8] = '{7'h02, 7'h04, 7'h05, 7'h06, 7'h07, 7'h09, 7'h0a, 7'h0b};
  logic [6:0] edge_ofs [2] = '{7'h0c, 7'h1f};
  logic [6:0] cram_ofs [2] = '{7'h70, 7'h7f};

  bdm_data_memory bdm_data_memory_i (
    .clk_sys_i(clk_sys_i),
    .sys_rst_i(sys_rst_i),
    .other_rst_i(other_rst_i),
    .ce_i(ce_i),
    .req_i(req_i),
    .watchdog_clear_instr_i(pwr[2]),
    .sleep_instr_i(pwr[1]),
    .watchdog_timer_expired_i(pwr[0]),
    .periph_o(periph_o),
    .periph_rdata_i(prd),
    .rd_data_o(rd_data_o),
    .result_o(res),
    .arith_reset_flags_o(flags),
    .working_accumulator_o(accum),
    .bank_number_select_o(bank),
    .program_counter_low_o(),
    .program_counter_latch_high_o(),
    .interrupt_control_o(),
    .pointer_zero_o(),
    .pointer_one_o()
  );

  bdm_periph_model bdm_periph_model_i (
    .clk_sys_i(clk_sys_i),
    .periph_i(periph_o),
    .rdata_o(prd)
  );

  // ****************************************************************
  // tasks
  // ****************************************************************
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    n_checks++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : chk

  task stop_test;
    if (n_errors == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask : stop_test

  task do_op(input bdm_pkg::bdm_op_t op, input logic tf, input logic [6:0] ofs,
    input logic [7:0] a, input logic [7:0] b);
    @(posedge clk_sys_i);
    req_i <= '{op, tf, ofs, a, b};
    @(posedge clk_sys_i);
    req_i.op <= bdm_pkg::BDM_OP_NONE;
    #1;
  endtask : do_op

  task wr(input logic [6:0] ofs, input logic [7:0] a);
    do_op(bdm_pkg::BDM_OP_WRITE, 1'b1, ofs, a, 8'h00);
  endtask : wr

  task rd(input logic [6:0] ofs);
    do_op(bdm_pkg::BDM_OP_READ, 1'b0, ofs, 8'h00, 8'h00);
  endtask : rd

  task pulse(input logic [2:0] p);
    @(posedge clk_sys_i);
    pwr <= p;
    @(posedge clk_sys_i);
    pwr <= 3'h0;
    #1;
  endtask : pulse

  // subtract flags worked out by comparison, not by the adder form
  function automatic logic [2:0] exp_flags(input logic sub, input logic [7:0] a, input logic [7:0] b);
    logic [8:0] s;
    s = {1'b0, a} + {1'b0, b};
    if (sub)
      return {a == b, a[3:0] >= b[3:0], a >= b};
    return {s[7:0] == 8'h00, (a[3:0] + b[3:0]) > 15, s[8]};
  endfunction : exp_flags

  // ****************************************************************
  // sequence
  // ****************************************************************
  initial
  begin
    clk_sys_i = 1'b0;
    forever #25 clk_sys_i = ~clk_sys_i;
  end

  initial
  begin
    #100us;
    n_errors++;
    stop_test();
  end

  initial
  begin
    repeat (3) @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(16'(flags), 16'h0018);
    chk(16'(bank), 16'h0000);
    foreach (core_ofs[i])
    begin
      wr(7'h08, 8'h05);
      wr(core_ofs[i], 8'(8'ha0 + i));
      wr(7'h08, 8'h1a);
      rd(core_ofs[i]);
      chk(16'(rd_data_o), 16'(8'(8'ha0 + i)));
    end
    chk(16'(accum), 16'h00a5);
    rd(7'h08);
    chk(16'(rd_data_o), 16'h001a);
    wr(7'h08, 8'hff);
    chk(16'(bank), 16'h001f);
    foreach (edge_ofs[i])
    begin
      wr(7'h08, 8'h01);
      wr(edge_ofs[i], 8'(8'h55 + i));
      chk(16'({periph_o.wr, periph_o.addr}), 16'({1'b1, 5'h01, edge_ofs[i]}));
      rd(edge_ofs[i]);
      @(posedge clk_sys_i);
      #1;
      chk(16'(rd_data_o), 16'(8'(8'h55 + i)));
      wr(cram_ofs[i], 8'(8'h3c + i));
      wr(7'h08, 8'h1f);
      rd(cram_ofs[i]);
      chk(16'(rd_data_o), 16'(8'(8'h3c + i)));
    end
    wr(7'h08, 8'h01);
    wr(7'h20, 8'haa);
    rd(7'h20);
    chk(16'(rd_data_o), 16'h0000);
    wr(7'h08, 8'h00);
    wr(7'h6f, 8'h66);
    rd(7'h6f);
    chk(16'(rd_data_o), 16'h0066);
    for (int i = 0; i < 8; i++)
    begin
      do_op(i < 4 ? bdm_pkg::BDM_OP_ADD : bdm_pkg::BDM_OP_SUB, 1'b0, 7'h09, va[i], vb[i]);
      chk(16'(flags[2:0]), 16'(exp_flags(i >= 4, va[i], vb[i])));
      chk(16'(res), 16'(8'(i < 4 ? va[i] + vb[i] : va[i] - vb[i])));
    end
    do_op(bdm_pkg::BDM_OP_ADD, 1'b1, 7'h03, 8'h01, 8'h01);
    chk(16'(flags[2:0]), 16'h0000);
    do_op(bdm_pkg::BDM_OP_ROT_RIGHT, 1'b0, 7'h09, 8'h01, 8'h00);
    chk(16'(flags[0]), 16'h0001);
    do_op(bdm_pkg::BDM_OP_ROT_LEFT, 1'b0, 7'h09, 8'h01, 8'h00);
    chk(16'(flags[0]), 16'h0000);
    do_op(bdm_pkg::BDM_OP_ROT_LEFT, 1'b0, 7'h09, 8'h80, 8'h00);
    chk(16'(flags[0]), 16'h0001);
    pulse(3'b001);
    chk(16'(flags[4:3]), 16'h0001);
    wr(7'h03, 8'hff);
    chk(16'(flags), 16'h000f);
    pulse(3'b010);
    chk(16'(flags[4:3]), 16'h0002);
    wr(7'h03, 8'h03);
    do_op(bdm_pkg::BDM_OP_CLEAR, 1'b1, 7'h03, 8'h00, 8'h00);
    chk(16'(flags), 16'h0017);
    pulse(3'b101);
    chk(16'(flags), 16'h001f);
    @(posedge clk_sys_i);
    other_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    other_rst_i <= 1'b0;
    #1;
    chk(16'(flags), 16'h001f);
    chk(16'(accum), 16'h0000);
    ce_i <= 1'b0;
    do_op(bdm_pkg::BDM_OP_SUB, 1'b0, 7'h09, 8'h03, 8'h05);
    ce_i <= 1'b1;
    chk(16'(flags), 16'h001f);
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b1;
    @(posedge clk_sys_i);
    sys_rst_i <= 1'b0;
    #1;
    chk(16'(flags), 16'h0018);
    chk(16'(bank), 16'h0000);
    stop_test();
  end
endmodule : tb_top
